//--- hdl/acc_conversion_control.sv
// conversion sequencing, power scaling and output enable logic
`timescale 1ns/10ps
module acc_conversion_control
   import acc_pkg::*;
#(
   parameter int CONV_CYCLES = acc_pkg::CONV_CYC,
   parameter int ACQ_CYCLES = acc_pkg::ACQ_CYC
) (
   // clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // conversion control
   input wire logic CONVERSION_START_N,
   input wire logic POWER_DOWN_INPUT,
   input wire logic [1:0] MODE_SELECT,
   // result from the decision array
   input wire logic [acc_pkg::DATA_W-1:0] DECISION_CODE,
   // interface configuration
   input wire logic OUTPUT_CODING_SELECT,
   input wire logic INTERFACE_TYPE_SELECT,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic SER_SHIFT,
   // status
   output logic BUSY,
   output logic REDUCED_POWER,
   // shared data bus
   output logic [acc_pkg::DATA_W-1:0] DATA_OUT,
   output logic [acc_pkg::DATA_W-1:0] DATA_OE
);
   import acc_pkg::*;

   typedef struct packed {
      acc_state_type state;
      logic [CNT_W-1:0] cnt;
      logic start_n_d;
      logic busy;
      logic low_power;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] shifter;
      logic [DATA_W-1:0] dout;
      logic [DATA_W-1:0] oe;
   } acc_regs_type;

   acc_regs_type r_reg;
   acc_regs_type r_next;
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;
   logic start_fall;
   logic selected;
   logic [DATA_W-1:0] coded;

   // reset release through two flip-flops
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // start edge, independent of the output controls
   assign start_fall = r_reg.start_n_d & ~CONVERSION_START_N;
   assign selected = ~CS_N & ~RD_N;
   // output coding: flip msb for straight binary
   assign coded = OUTPUT_CODING_SELECT ?
      {~DECISION_CODE[SIGN_BIT], DECISION_CODE[SIGN_BIT-1:0]} : DECISION_CODE;

   // next-state logic
   always_comb begin
      r_next = r_reg;
      r_next.start_n_d = CONVERSION_START_N;
      case (r_reg.state)
         ST_IDLE: begin
            // power-down only parks an idle or acquiring converter
            if (start_fall && !POWER_DOWN_INPUT) begin
               r_next.state = ST_CONV;
               r_next.cnt = '0;
               r_next.busy = 1'b1;
               r_next.low_power = 1'b0;
            end
         end
         ST_CONV: begin
            // runs to completion regardless of start or power-down
            if (r_reg.cnt == CNT_W'(CONV_CYCLES - 1)) begin
               r_next.result = coded;
               r_next.busy = 1'b0;
               r_next.cnt = '0;
               r_next.low_power = (MODE_SELECT == MODE_POWER_SCALED);
               r_next.state = (MODE_SELECT == MODE_POWER_SCALED) ? ST_ACQ : ST_IDLE;
            end else begin
               r_next.cnt = r_reg.cnt + CNT_W'(1);
            end
         end
         ST_ACQ: begin
            // self-timed acquisition, then relaunch while start stays low
            if (CONVERSION_START_N || POWER_DOWN_INPUT) begin
               r_next.state = ST_IDLE;
            end else if (r_reg.cnt == CNT_W'(ACQ_CYCLES - 1)) begin
               r_next.state = ST_CONV;
               r_next.cnt = '0;
               r_next.busy = 1'b1;
               r_next.low_power = 1'b0;
            end else begin
               r_next.cnt = r_reg.cnt + CNT_W'(1);
            end
         end
         default: begin
            r_next.state = ST_IDLE;
         end
      endcase
      // serial shifter loads the new result, shifts msb first on request
      if (r_reg.state == ST_CONV && r_next.state != ST_CONV) begin
         r_next.shifter = coded;
      end else if (selected && INTERFACE_TYPE_SELECT && SER_SHIFT) begin
         r_next.shifter = {r_reg.shifter[DATA_W-2:0], 1'b0};
      end
      // bus drive, live in every phase including acquisition
      r_next.oe = '0;
      r_next.dout = '0;
      if (selected) begin
         if (INTERFACE_TYPE_SELECT) begin
            r_next.oe[SER_BIT] = 1'b1;
            r_next.dout[SER_BIT] = r_next.shifter[DATA_W-1];
         end else begin
            r_next.oe = '1;
            r_next.dout = r_next.result;
         end
      end
   end

   // state register, frozen while the enable is low
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         r_reg.state <= ST_IDLE;
         r_reg.cnt <= '0;
         r_reg.start_n_d <= 1'b1;
         r_reg.busy <= 1'b0;
         r_reg.low_power <= 1'b0;
         r_reg.result <= RESULT_RST;
         r_reg.shifter <= RESULT_RST;
         r_reg.dout <= '0;
         r_reg.oe <= '0;
      end else if (CLK_EN) begin
         r_reg <= r_next;
      end
   end

   assign BUSY = r_reg.busy;
   assign REDUCED_POWER = r_reg.low_power;
   assign DATA_OUT = r_reg.dout;
   assign DATA_OE = r_reg.oe;

   // start edge while idle launches a conversion
   AST_START_LAUNCH: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && r_reg.state == ST_IDLE && start_fall && !POWER_DOWN_INPUT) |=> BUSY)
      else $error("start edge did not raise busy");
   // busy and the conversion state hold for two cycles after busy rises
   AST_NO_ABORT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $rose(BUSY) |-> (BUSY && r_reg.state == ST_CONV)[*2])
      else $error("conversion aborted early");
   // busy falls exactly when the result is stored
   AST_RESULT_AT_END: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $fell(BUSY) |-> r_reg.result == $past(coded))
      else $error("result not formed at end of conversion");
   // busy high only in the conversion state
   AST_BUSY_STATE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      BUSY == (r_reg.state == ST_CONV))
      else $error("busy disagrees with phase");
   // no drive unless both selects were low
   AST_HIZ: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (DATA_OE != '0) |-> $past(selected))
      else $error("bus driven while deselected");
   // parallel drives all lanes
   AST_PAR_ALL: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && selected && !INTERFACE_TYPE_SELECT) |=> DATA_OE == '1)
      else $error("parallel bus not driven");
   // self-retrigger only in the power-scaled mode
   AST_ACQ_MODE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (r_reg.state == ST_ACQ) |-> REDUCED_POWER)
      else $error("acquisition state outside power-scaled");
   // reduced power drops as a conversion starts
   AST_POWER_UP: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $rose(BUSY) |-> !REDUCED_POWER)
      else $error("converting in reduced power");

   // conversion phases seen from the state register
   sequence seq_conv_last;
      r_reg.state == ST_CONV && r_reg.cnt == CNT_W'(CONV_CYCLES - 1);
   endsequence
   sequence seq_acq_last;
      r_reg.state == ST_ACQ && r_reg.cnt == CNT_W'(ACQ_CYCLES - 1);
   endsequence
   sequence seq_conv_done;
      !BUSY && r_reg.state != ST_CONV;
   endsequence

   // last decision cycle ends busy
   AST_END_DROPS_BUSY: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN ##0 seq_conv_last)
      |=> seq_conv_done)
      else $error("busy did not fall at end of conversion");

   // power-down during conversion keeps busy up
   AST_PD_NO_ABORT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && BUSY && POWER_DOWN_INPUT && r_reg.cnt != CNT_W'(CONV_CYCLES - 1))
      |=> BUSY)
      else $error("power-down aborted a conversion");

   // start edges while busy change nothing
   AST_BUSY_IGNORES_START: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && BUSY && start_fall && r_reg.cnt != CNT_W'(CONV_CYCLES - 1))
      |=> (BUSY && r_reg.state == ST_CONV))
      else $error("start edge disturbed a conversion");

   // held start relaunches after the timed acquisition
   AST_RETRIGGER: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ((CLK_EN && !CONVERSION_START_N && !POWER_DOWN_INPUT) ##0 seq_acq_last)
      |=> BUSY)
      else $error("no relaunch after acquisition");

   // released start or power-down ends the self-repeating run
   AST_ACQ_EXIT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && r_reg.state == ST_ACQ && (CONVERSION_START_N || POWER_DOWN_INPUT))
      |=> (r_reg.state == ST_IDLE && !BUSY))
      else $error("acquisition did not stop");

   // outside the power-scaled mode a conversion ends in idle
   AST_ONE_SHOT: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ((CLK_EN && MODE_SELECT != MODE_POWER_SCALED) ##0 seq_conv_last)
      |=> r_reg.state == ST_IDLE)
      else $error("self-retrigger outside power-scaled mode");

   // power-scaled conversion end lowers power
   AST_POWER_DOWN_END: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ((CLK_EN && MODE_SELECT == MODE_POWER_SCALED) ##0 seq_conv_last)
      |=> REDUCED_POWER)
      else $error("power not reduced after conversion");

   // start works with the bus deselected
   AST_START_FREE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && r_reg.state == ST_IDLE && start_fall && !POWER_DOWN_INPUT && (CS_N || RD_N))
      |=> BUSY)
      else $error("start depended on the selects");

   // serial mode drives only the shared lane
   AST_SER_LANE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && selected && INTERFACE_TYPE_SELECT)
      |=> DATA_OE == (DATA_W'(1) << SER_BIT))
      else $error("serial lane enable wrong");

   // sign bit follows the coding select
   AST_CODING: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN ##0 seq_conv_last)
      |=> r_reg.result[SIGN_BIT] == ($past(DECISION_CODE[SIGN_BIT]) ^ $past(OUTPUT_CODING_SELECT)))
      else $error("output coding wrong");

   // bus keeps serving the result during acquisition
   AST_ACQ_BUS_LIVE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && r_reg.state == ST_ACQ && selected && !INTERFACE_TYPE_SELECT)
      |=> DATA_OUT == r_reg.result)
      else $error("bus idle during acquisition");

   // enable low freezes every field of r_reg
   AST_FREEZE: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (!CLK_EN)
      |=> $stable(r_reg))
      else $error("state moved while frozen");

   // power-down keeps an idle converter parked
   AST_IDLE_PD_BLOCK: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && r_reg.state == ST_IDLE && POWER_DOWN_INPUT)
      |=> !BUSY)
      else $error("start taken during power-down");

   // parallel read shows the stored result
   AST_PAR_DATA: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      (CLK_EN && selected && !INTERFACE_TYPE_SELECT && r_reg.state != ST_CONV)
      |=> DATA_OUT == r_reg.result)
      else $error("parallel data wrong");
endmodule // acc_conversion_control

//--- include/acc_pkg.sv
// shared constants and types for the conversion control block
package acc_pkg;
   // result width
   localparam int DATA_W = 16;
   // clock rate in kHz, period 8 ns
   localparam int CLK_KHZ = 125000;
   // conversion phase length in ns and derived cycles (rounded down, at least one)
   localparam int CONV_NS = 700;
   localparam int CONV_CYC = (CONV_NS * CLK_KHZ / 1000000) < 1 ? 1 : (CONV_NS * CLK_KHZ / 1000000);
   // self-timed acquisition in the power-scaled mode, ns and cycles (rounded up)
   localparam int ACQ_NS = 800;
   localparam int ACQ_CYC = (ACQ_NS * CLK_KHZ + 999999) / 1000000;
   // counter width
   localparam int CNT_W = 12;
   // reset values
   localparam logic [DATA_W-1:0] RESULT_RST = 16'h0000;
   // mode encoding on the mode select port
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_TOP_SPEED = 2'h1;
   localparam logic [1:0] MODE_POWER_SCALED = 2'h2;
   // position of the sign bit flipped for straight binary coding
   localparam int SIGN_BIT = 15;
   // position of the serial output on the shared data bus
   localparam int SER_BIT = 0;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ACQ} acc_state_type;
endpackage

//--- test/acc_host_model.sv
// host model that selects the converter and reads one word
`timescale 1ns/10ps
module acc_host_model (
   // clock and bus from the converter
   input wire logic clk,
   input wire logic [acc_pkg::DATA_W-1:0] data_out,
   input wire logic [acc_pkg::DATA_W-1:0] data_oe,
   // selects to the converter
   output logic cs_n = 1'b1,
   output logic rd_n = 1'b1,
   output logic ser_shift = 1'b0
);
   import acc_pkg::*;
   // select first, sample bus with read off, then read the word
   task automatic read(output logic [DATA_W-1:0] part, word);
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (2) @(negedge clk);
      part = data_oe;
      @(posedge clk);
      rd_n <= 1'b0;
      repeat (2) @(negedge clk);
      word = data_out;
      @(posedge clk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask
   // serial word on the shared lane, one shift per clock, msb first
   task automatic ser_read(output logic [DATA_W-1:0] lanes, word);
      word = '0;
      lanes = '0;
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      @(posedge clk);
      ser_shift <= 1'b1;
      for (int i = 0; i < DATA_W; i++) begin
         @(negedge clk);
         if (i == 0) lanes = data_oe;
         word[DATA_W-1-i] = data_out[SER_BIT];
         @(posedge clk);
      end
      ser_shift <= 1'b0;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask
endmodule // acc_host_model

//--- test/tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/10ps
module tb;
   import acc_pkg::*;
   localparam int CONV = 4;
   localparam int ACQ = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start_n = 1'b1;
   logic pd = 1'b0;
   logic [1:0] mode = MODE_NORMAL;
   logic [DATA_W-1:0] code = 16'h0000;
   logic osel = 1'b0;
   logic en = 1'b1;
   logic ser = 1'b0;
   logic sh;
   logic cs_n, rd_n, busy, rp;
   logic [DATA_W-1:0] dout, doe, part, word;
   logic [DATA_W-1:0] expq[$];
   int failures = 0;
   int tests_run = 0;
   int len;
   // clock
   initial begin
      forever #4 clk = ~clk;
   end
   acc_conversion_control #(.CONV_CYCLES(CONV), .ACQ_CYCLES(ACQ)) DUT (.REF_CLK(clk),
      .RESET_N(rst_n), .CLK_EN(en), .CONVERSION_START_N(start_n), .POWER_DOWN_INPUT(pd),
      .MODE_SELECT(mode), .DECISION_CODE(code), .OUTPUT_CODING_SELECT(osel),
      .INTERFACE_TYPE_SELECT(ser), .CS_N(cs_n), .RD_N(rd_n), .SER_SHIFT(sh), .BUSY(busy),
      .REDUCED_POWER(rp), .DATA_OUT(dout), .DATA_OE(doe));
   acc_host_model HOST (.clk(clk), .data_out(dout), .data_oe(doe), .cs_n(cs_n), .rd_n(rd_n),
      .ser_shift(sh));
   // compare and count
   task automatic check(input logic [DATA_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // counts, verdict, end of run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one conversion; start toggles and power-down stays high while busy unless held
   task automatic run_conv(input logic hold);
      logic [DATA_W-1:0] c;
      logic o;
      c = $urandom();
      o = $urandom();
      expq.push_back(c ^ (16'(o) << SIGN_BIT)); // binary flips sign bit
      @(posedge clk);
      code <= c;
      osel <= o;
      start_n <= 1'b0;
      len = 0;
      for (int n = 0; n < 8 && busy !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      while (busy === 1'b1 && len < 300) begin
         len++;
         @(posedge clk);
         start_n <= hold ? 1'b0 : len[0];
         pd <= !hold;
         #1;
      end
      check(16'(len), 16'(CONV));
      if (!hold) begin
         @(posedge clk);
         pd <= 1'b0;
         start_n <= 1'b1;
      end
   endtask
   // busy must stay low for a span
   task automatic quiet(input int cyc);
      int b;
      b = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1;
         if (busy === 1'b1) b++;
      end
      check(16'(b), 16'h0000);
   endtask
   // host read against the model queue
   task automatic read_check;
      HOST.read(part, word);
      check(part, 16'h0000);
      check(word, expq.pop_front());
   endtask
   // main sequence
   initial begin
      void'($urandom(54544));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         mode <= i[0] ? MODE_TOP_SPEED : MODE_NORMAL;
         run_conv(1'b0);
         read_check();
      end
      $display("test single conversions done");
      mode <= MODE_TOP_SPEED; // not power-scaled, so a held start does not relaunch and this result is kept
      run_conv(1'b1);
      quiet(2 * ACQ + 4);
      @(posedge clk);
      start_n <= 1'b1;
      read_check();
      $display("test held start done");
      mode <= MODE_POWER_SCALED;
      run_conv(1'b1);
      len = 0;
      for (int n = 0; n < 50 && busy !== 1'b1; n++) begin
         if (rp === 1'b1) len++;
         @(posedge clk);
         #1;
      end
      check(16'(len), 16'(ACQ));
      check({15'h0000, busy}, 16'h0001);
      @(posedge clk);
      start_n <= 1'b1;
      pd <= 1'b1;
      for (int n = 0; n < 300 && busy === 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      pd <= 1'b0;
      #1;
      check({15'h0000, rp}, 16'h0001);
      quiet(2 * ACQ + 4);
      read_check();
      $display("test power-scaled done");
      mode <= MODE_NORMAL;
      run_conv(1'b0);
      ser <= 1'b1;
      HOST.ser_read(part, word);
      ser <= 1'b0;
      check(part, 16'h0001);
      check(word, expq.pop_front());
      $display("test serial read done");
      // frozen enable holds off a start until released
      expq.push_back(code ^ (16'(osel) << SIGN_BIT));
      @(posedge clk);
      en <= 1'b0;
      start_n <= 1'b0;
      quiet(6);
      @(posedge clk);
      en <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({15'h0000, busy}, 16'h0001);
      for (int n = 0; n < 300 && busy === 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      start_n <= 1'b1;
      read_check();
      $display("test clock enable done");
      print_verdict();
   end
   // watchdog
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule // tb
